// >>> nested_interrupt_control_tb.sv
module nested_interrupt_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import nic_pkg::*;
   logic        clk = 0, nrst = 0, nmi = 0, fl = 0, set_gie = 0, do_ret = 0;
   logic [3:0]  wk = '0;
   logic [31:6] pi = '0;
   logic [31:0] msk = '0;
   nic_core_t   core;
   nic_req_t    req;
   logic        gie;
   logic [7:0]  dep;
   int          bad_count = 0, n_checks = 0, cyc = 0;
   always #10 clk = ~clk;
   nic_core_model core_u (.clk(clk), .req(req), .set_gie(set_gie), .do_ret(do_ret), .core(core));
   nic_ctrl dut_u (.clk(clk), .nrst(nrst), .nmi_in(nmi), .flash_irq(fl), .wake_irq(wk), .periph_irq(pi),
      .source_enable_mask_low(msk[15:0]), .source_enable_mask_high(msk[31:16]), .core(core), .req(req),
      .processor_status_word_gie(gie), .nest_depth(dep));
   task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task pulse_gie;
      set_gie = 1;
      @(negedge clk);
      set_gie = 0;
   endtask
   task automatic wait_req;
      for (int i = 0; i < 10 && req.valid !== 1'h1; i++) @(negedge clk);
   endtask
   // release flash, wakeup and nmi (periph_irq stays), let the core take the request
   task drop;
      fl = 0;
      wk = '0;
      nmi = 0;
      repeat (3) @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         print_verdict;
      end
   end
   task test_blocked;
      msk = 32'h0000_0022; // only served lines enabled
      fl = 1;
      repeat (8) @(negedge clk);
      chk("blocked", req.valid, 8'h00);
   endtask
   task test_flash;
      pulse_gie;
      wait_req;
      chk("flash vector", req.vector, 8'h01);
      drop;
      chk("gie cleared", gie, 8'h00);
      chk("depth one", dep, 8'h01);
   endtask
   task test_nmi;
      nmi = 1;
      wait_req;
      chk("nmi nests", req.nmi, 8'h01);
      drop;
      chk("depth two", dep, 8'h02);
   endtask
   task test_wake;
      pi[6] = 1;
      wk[0] = 1;
      pulse_gie;
      wait_req;
      chk("wake vector", req.vector, 8'h05);
      chk("wake maskable", req.nmi, 8'h00);
      drop;
      chk("depth three", dep, 8'h03);
   endtask
   task test_masked;
      pulse_gie;
      repeat (8) @(negedge clk);
      chk("masked line", req.valid, 8'h00);
      chk("gie reopened", gie, 8'h01);
   endtask
   task test_return;
      do_ret = 1;
      @(negedge clk);
      do_ret = 0;
      repeat (2) @(negedge clk);
      chk("return", dep, 8'h02);
   endtask
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1;
      test_blocked;
      test_flash;
      test_nmi;
      test_wake;
      test_masked;
      test_return;
      print_verdict;
   end
endmodule // nested_interrupt_control_tb

// >>> nic_core_model.sv
module nic_core_model (
   input  wire logic              clk,
   input  wire nic_pkg::nic_req_t req,
   input  wire logic              set_gie,
   input  wire logic              do_ret,
   output nic_pkg::nic_core_t     core
);
   timeunit 1ns;
   timeprecision 1ns;
   import nic_pkg::*;
   initial core = '0;
   // takes a held request once, drives a one-cycle load of the flag
   always @(posedge clk) begin
      core.ack     <= req.valid & ~core.ack;
      core.gie_wr  <= set_gie;
      core.gie_val <= set_gie;
      core.ret     <= do_ret;
   end
endmodule // nic_core_model

// >>> nic_ctrl.sv
module nic_ctrl (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic                   nmi_in,
   input  wire logic                   flash_irq,
   input  wire logic [3:0]             wake_irq,
   input  wire logic [31:6]            periph_irq,
   input  wire logic [15:0]            source_enable_mask_low,
   input  wire logic [15:0]            source_enable_mask_high,
   input  wire nic_pkg::nic_core_t     core,
   output nic_pkg::nic_req_t           req,
   output logic                        processor_status_word_gie,
   output logic [7:0]                  nest_depth
);
   import nic_pkg::*;

   logic [31:0] raw;
   logic [31:0] pending;
   logic        nmi_s1;
   logic        nmi_s2;
   logic        nmi_d;
   logic        nmi_pend;
   logic        next_nmi_pend;
   logic        next_gie;
   logic [7:0]  next_depth;
   nic_req_t    next_req;
   nic_state_t  state;
   nic_state_t  next_state;
   logic [31:0] irq_s1;
   logic [31:0] irq_s2;
   logic [31:0] pending_d;

   function automatic logic [4:0] first_set(input logic [31:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NIC_NUM_IRQ - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      raw = {periph_irq, wake_irq[0], wake_irq[1], wake_irq[2], wake_irq[3], flash_irq, 1'b0};
      pending = irq_s2 & {source_enable_mask_high, source_enable_mask_low};
   end

   always_comb begin
      next_nmi_pend = nmi_pend | (nmi_s2 & ~nmi_d);
      next_gie      = processor_status_word_gie;
      next_depth    = nest_depth;
      next_req      = req;
      next_state    = state;
      if (core.gie_wr) begin
         next_gie = core.gie_val;
      end
      if (core.ret && nest_depth != 8'h00) begin
         next_depth = nest_depth - 8'h01;
      end
      case (state)
         NIC_IDLE: begin
            if (nmi_pend) begin
               next_req = '{valid: 1'b1, nmi: 1'b1, vector: 5'h00};
               next_state = NIC_ENTERING;
            end else if (processor_status_word_gie && pending != 32'h0) begin
               next_req = '{valid: 1'b1, nmi: 1'b0, vector: first_set(pending)};
               next_state = NIC_ENTERING;
            end
         end
         NIC_ENTERING: begin
            if (core.ack) begin
               next_req.valid = 1'b0;
               next_state = NIC_IDLE;
               next_depth = next_depth + 8'h01;
               if (req.nmi) begin
                  next_nmi_pend = nmi_s2 & ~nmi_d;
               end else begin
                  next_gie = 1'b0;
               end
            end
         end
         default: next_state = NIC_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         nmi_s1 <= 1'b0;
         nmi_s2 <= 1'b0;
         nmi_d <= 1'b0;
         irq_s1 <= 32'h0;
         irq_s2 <= 32'h0;
         pending_d <= 32'h0;
         nmi_pend <= 1'b0;
         processor_status_word_gie <= NIC_GIE_RST;
         nest_depth <= NIC_DEPTH_RST;
         req <= '0;
         state <= NIC_IDLE;
      end else begin
         nmi_s1 <= nmi_in;
         nmi_s2 <= nmi_s1;
         nmi_d <= nmi_s2;
         irq_s1 <= raw;
         irq_s2 <= irq_s1;
         pending_d <= pending;
         nmi_pend <= next_nmi_pend;
         processor_status_word_gie <= next_gie;
         nest_depth <= next_depth;
         req <= next_req;
         state <= next_state;
      end
   end

   // line 0 is never presented as a maskable vector
   chk_rsvd_never: assert property (
      @(posedge clk) disable iff (!nrst)
      req.valid
      |-> (req.nmi || req.vector != 5'h00))
      else $error("reserved line raised");

   // vector of a new maskable request was enabled and pending
   chk_masked_src: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(req.valid) && !req.nmi
      |-> pending_d[req.vector])
      else $error("disabled source raised");

   chk_masked_none: assert property (
      @(posedge clk) disable iff (!nrst)
      state == NIC_IDLE && !nmi_pend && pending == 32'h0
      |=> !req.valid)
      else $error("request without enabled source");

   chk_gie_block: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(req.valid) && !req.nmi
      |-> $past(processor_status_word_gie))
      else $error("nesting while blocked");

   // flag moves only on a load or a maskable acceptance
   chk_gie_steady: assert property (
      @(posedge clk) disable iff (!nrst)
      !core.gie_wr && !(req.valid && core.ack)
      |=> processor_status_word_gie == $past(processor_status_word_gie))
      else $error("gie changed by itself");

   chk_ack_clears: assert property (
      @(posedge clk) disable iff (!nrst)
      req.valid && !req.nmi && core.ack && !core.gie_wr
      |=> !processor_status_word_gie)
      else $error("gie not cleared");

   chk_nmi_wins: assert property (
      @(posedge clk) disable iff (!nrst)
      state == NIC_IDLE && nmi_pend
      |=> req.valid && req.nmi)
      else $error("nmi not taken");

   chk_nmi_holds: assert property (
      @(posedge clk) disable iff (!nrst)
      req.valid && req.nmi && !core.ack
      |=> req.valid && req.nmi)
      else $error("nmi request dropped");

   // a fresh nmi edge in the acceptance cycle is kept for the next round
   chk_nmi_renest: assert property (
      @(posedge clk) disable iff (!nrst)
      req.valid && req.nmi && core.ack && nmi_s2 && !nmi_d
      |=> nmi_pend)
      else $error("nested nmi lost");

   chk_gie_write: assert property (
      @(posedge clk) disable iff (!nrst)
      core.gie_wr && !(req.valid && core.ack)
      |=> processor_status_word_gie == $past(core.gie_val))
      else $error("gie write lost");

   chk_gie_reopen: assert property (
      @(posedge clk) disable iff (!nrst)
      state == NIC_IDLE && !nmi_pend && processor_status_word_gie && pending != 32'h0
      |=> req.valid && !req.nmi)
      else $error("open nesting not taken");

   chk_depth_up: assert property (
      @(posedge clk) disable iff (!nrst)
      req.valid && core.ack && !core.ret && nest_depth != 8'hFF
      |=> nest_depth == $past(nest_depth) + 8'h01)
      else $error("depth not counted");

   chk_depth_down: assert property (
      @(posedge clk) disable iff (!nrst)
      core.ret && !(req.valid && core.ack) && nest_depth != 8'h00
      |=> nest_depth == $past(nest_depth) - 8'h01)
      else $error("return not counted");

   chk_flash_line: assert property (
      @(posedge clk) disable iff (!nrst)
      1'b1
      |-> irq_s1[1] == $past(flash_irq))
      else $error("flash not on line 1");

   // wakeup output 0 lands on line 5, output 3 on line 2
   chk_wake_lines: assert property (
      @(posedge clk) disable iff (!nrst)
      1'b1
      |-> irq_s1[5:2] == $past({wake_irq[0], wake_irq[1], wake_irq[2], wake_irq[3]}))
      else $error("wakeup lines misplaced");

endmodule // nic_ctrl

// >>> nic_pkg.sv
package nic_pkg;

   localparam int unsigned NIC_NUM_IRQ    = 32;
   localparam int unsigned NIC_IRQ_RSVD   = 0;
   localparam int unsigned NIC_IRQ_FLASH  = 1;
   localparam int unsigned NIC_IRQ_WAKE3  = 2;
   localparam int unsigned NIC_IRQ_WAKE2  = 3;
   localparam int unsigned NIC_IRQ_WAKE1  = 4;
   localparam int unsigned NIC_IRQ_WAKE0  = 5;
   localparam logic [15:0] NIC_MASK_LOW_RST  = 16'h0000;
   localparam logic [15:0] NIC_MASK_HIGH_RST = 16'h0000;
   localparam logic        NIC_GIE_RST       = 1'b0;
   localparam logic [7:0]  NIC_DEPTH_RST     = 8'h00;

   typedef enum logic [1:0] {
      NIC_IDLE     = 2'b00,
      NIC_ENTERING = 2'b01
   } nic_state_t;

   // request presented to the core
   typedef struct packed {
      logic       valid;
      logic       nmi;
      logic [4:0] vector;
   } nic_req_t;

   // core-side control
   typedef struct packed {
      logic       ack;
      logic       ret;
      logic       gie_wr;
      logic       gie_val;
   } nic_core_t;

endpackage
